// >>> epp_map.svh
/*
 Register offsets, reset values and field positions of the port block.
 Assumes a 32-bit AXI4-Lite bus with byte addresses and word registers.
*/
`ifndef EPP_MAP_SVH
`define EPP_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define EPP_ADDR_W 8
`define EPP_OFF_PIN 8'h00
`define EPP_OFF_DIR 8'h04
`define EPP_OFF_LAT 8'h08
`define EPP_OFF_ANA 8'h0C
`define EPP_OFF_PU 8'h10
`define EPP_OFF_OD 8'h14
`define EPP_OFF_SLEW 8'h18
`define EPP_OFF_THR 8'h1C
`define EPP_OFF_CTL 8'h20

// ****************************************
// Fields and reset values
// ****************************************
`define EPP_ANA_W 6
`define EPP_CTL_GPD 0
`define EPP_MASK_LANE 1
`define EPP_RST_DIR 8'hFF
`define EPP_RST_LAT 8'h00
`define EPP_RST_ANA 6'h3F
`define EPP_RST_PU 8'hFF
`define EPP_RST_OD 8'h00
`define EPP_RST_SLEW 8'hFF
`define EPP_RST_THR 8'h00
`define EPP_RST_GPD 1'b1
`define EPP_SYNC_STAGES 2

`endif

// >>> epp_pkg.sv
/*
 Shared types of the port block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package epp_pkg;
  typedef logic [7:0] epp_byte_t;
  typedef logic [31:0] epp_word_t;
  typedef enum logic [1:0] {
    EPP_RESP_OKAY = 2'h0,
    EPP_RESP_SLVERR = 2'h2
  } epp_resp_e;
endpackage

// >>> epp_pin.sv
/*
 One pad slice: registered pad controls and the input synchroniser.
 Assumes next-state control bits from the register file, same clock.
*/
`timescale 1ns/1ps
module epp_pin #(
  parameter bit ANA_RST = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nxt_dir,
  input wire logic nxt_lat,
  input wire logic nxt_od,
  input wire logic nxt_slew,
  input wire logic nxt_pu,
  input wire logic nxt_ana,
  input wire logic nxt_st,
  input wire logic st_in,
  input wire logic ttl_in,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pad_slew_lim,
  output logic pad_pullup_en,
  output logic pad_analog_en,
  output logic pad_st_sel,
  output logic pin_sync
);
  logic out_ff, oe_n_ff, slew_ff, pu_ff, ana_ff, st_ff;
  logic sync1_ff, sync2_ff;

  // ****************************************
  // Pad controls, taken from next values
  // ****************************************
  // Built from next values so a write shows on pads at the same edge that stores it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      slew_ff <= 1'b1;
      pu_ff <= 1'b0;
      ana_ff <= ANA_RST; // Pins with no analog path come up digital
      st_ff <= 1'b0;
    end else begin
      out_ff <= nxt_lat;
      oe_n_ff <= nxt_dir | (nxt_od & nxt_lat);
      slew_ff <= nxt_slew;
      pu_ff <= nxt_pu & nxt_dir;
      ana_ff <= nxt_ana;
      st_ff <= nxt_st;
    end
  end

  // Threshold mux sits before stage one, so stage one feeds only stage two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= st_ff ? st_in : ttl_in;
      sync2_ff <= sync1_ff;
    end
  end

  assign pad_out = out_ff;
  assign pad_oe_n = oe_n_ff;
  assign pad_slew_lim = slew_ff;
  assign pad_pullup_en = pu_ff;
  assign pad_analog_en = ana_ff;
  assign pad_st_sel = st_ff;
  assign pin_sync = sync2_ff;

  // ****************************************
  // Checks
  // ****************************************
  a_drive_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    (!nxt_dir && !nxt_od) |=> (!pad_oe_n && pad_out == $past(nxt_lat)))
    else $error("driver not showing latch");
  a_sink_only: assert property (@(posedge aclk) disable iff (!aresetn)
    nxt_od |=> (pad_oe_n || !pad_out))
    else $error("open drain sourced high");
  a_pullup_out: assert property (@(posedge aclk) disable iff (!aresetn)
    !nxt_dir |=> !pad_pullup_en)
    else $error("pull-up on an output");
  a_analog_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    (nxt_ana && !nxt_dir && !nxt_od) |=> (!pad_oe_n && pad_analog_en))
    else $error("analog pin lost driver");
  a_sync_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(aresetn) && $past(aresetn, 2) && $past(pad_st_sel, 2))
    |-> pin_sync == $past(st_in, 2))
    else $error("synchroniser depth wrong");
endmodule

// >>> epp_port.sv
/*
 Eight-pin port bank: AXI4-Lite register file, pad control, pin readback.
 Assumes pad cells outside resolve pad_out/pad_oe_n and give both
 threshold comparator outputs; the pins are async to aclk.
*/
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "epp_map.svh"
module epp_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`EPP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire epp_pkg::epp_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`EPP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output epp_pkg::epp_word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire epp_pkg::epp_byte_t pad_st_in,
  input wire epp_pkg::epp_byte_t pad_ttl_in,
  output epp_pkg::epp_byte_t pad_out,
  output epp_pkg::epp_byte_t pad_oe_n,
  output epp_pkg::epp_byte_t pad_slew_lim,
  output epp_pkg::epp_byte_t pad_pullup_en,
  output epp_pkg::epp_byte_t pad_analog_en,
  output epp_pkg::epp_byte_t pad_st_sel
);
  import epp_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic aw_rdy_ff, w_rdy_ff, aw_got_ff, w_got_ff;
  logic [`EPP_ADDR_W-1:0] waddr_ff;
  epp_word_t wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, ar_rdy_ff, rvalid_ff;
  epp_resp_e bresp_ff, rresp_ff;
  epp_word_t rdata_ff;
  logic commit, wr_en, w_mapped, r_mapped;
  epp_byte_t dir_ff, lat_ff, pu_ff, od_ff, slew_ff, thr_ff;
  logic [`EPP_ANA_W-1:0] ana_ff;
  logic gpd_ff;
  epp_byte_t nxt_dir, nxt_lat, nxt_pu, nxt_od, nxt_slew, nxt_thr;
  logic [`EPP_ANA_W-1:0] nxt_ana;
  logic nxt_gpd;
  epp_byte_t ana_full, nxt_ana_full, pin_sync, pin_rd;
  epp_byte_t rmw_mask, pu_eff;
  epp_word_t rd_word;

  // ****************************************
  // Write address and data channels
  // ****************************************
  // Each channel taken on its own; ready drops until the response goes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      waddr_ff <= '0;
    end else if (s_axi_awvalid && aw_rdy_ff) begin
      aw_rdy_ff <= 1'b0;
      aw_got_ff <= 1'b1;
      waddr_ff <= {s_axi_awaddr[`EPP_ADDR_W-1:2], 2'b00};
    end else if (commit) begin
      aw_got_ff <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_rdy_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_rdy_ff <= 1'b1;
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && w_rdy_ff) begin
      w_rdy_ff <= 1'b0;
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (commit) begin
      w_got_ff <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_rdy_ff <= 1'b1;
    end
  end

  // Both halves present: the write lands this edge
  assign commit = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_en = commit && wstrb_ff[0];
  assign w_mapped = (waddr_ff <= `EPP_OFF_CTL);

  // Response raised at the same edge the write lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= EPP_RESP_OKAY;
    end else if (commit) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= w_mapped ? EPP_RESP_OKAY : EPP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ****************************************
  // Next values of the control registers
  // ****************************************
  // Lane 1 of a pin write selects bits; without it the whole byte moves
  // Registered strobe: the live bus may already carry the next write
  assign rmw_mask = wstrb_ff[`EPP_MASK_LANE] ?
    wdata_ff[15:8] : 8'hFF;
  assign pu_eff = nxt_pu & {8{~nxt_gpd}};

  always_comb begin
    nxt_dir = dir_ff;
    nxt_lat = lat_ff;
    nxt_ana = ana_ff;
    nxt_pu = pu_ff;
    nxt_od = od_ff;
    nxt_slew = slew_ff;
    nxt_thr = thr_ff;
    nxt_gpd = gpd_ff;
    if (wr_en) begin
      case (waddr_ff)
        `EPP_OFF_PIN: begin
          // Analog pins sample zero here, which can clear their latch
          nxt_lat = (pin_rd & ~rmw_mask) |
            (wdata_ff[7:0] & rmw_mask);
        end
        `EPP_OFF_DIR: nxt_dir = wdata_ff[7:0];
        `EPP_OFF_LAT: nxt_lat = wdata_ff[7:0];
        `EPP_OFF_ANA: nxt_ana = wdata_ff[`EPP_ANA_W-1:0];
        `EPP_OFF_PU: nxt_pu = wdata_ff[7:0];
        `EPP_OFF_OD: nxt_od = wdata_ff[7:0];
        `EPP_OFF_SLEW: nxt_slew = wdata_ff[7:0];
        `EPP_OFF_THR: nxt_thr = wdata_ff[7:0];
        `EPP_OFF_CTL: nxt_gpd = wdata_ff[`EPP_CTL_GPD];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Stored on the write edge; pads follow at that same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_ff <= `EPP_RST_DIR;
      lat_ff <= `EPP_RST_LAT;
    end else begin
      dir_ff <= nxt_dir;
      lat_ff <= nxt_lat;
    end
  end

  // Analog select comes up analog on every pin that has it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ana_ff <= `EPP_RST_ANA;
      thr_ff <= `EPP_RST_THR;
    end else begin
      ana_ff <= nxt_ana;
      thr_ff <= nxt_thr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pu_ff <= `EPP_RST_PU;
      od_ff <= `EPP_RST_OD;
      slew_ff <= `EPP_RST_SLEW;
      gpd_ff <= `EPP_RST_GPD;
    end else begin
      pu_ff <= nxt_pu;
      od_ff <= nxt_od;
      slew_ff <= nxt_slew;
      gpd_ff <= nxt_gpd;
    end
  end

  // Upper two pins have no analog path and stay digital
  assign ana_full = {2'b00, ana_ff};
  assign nxt_ana_full = {2'b00, nxt_ana};

  // ****************************************
  // Pad slices
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      epp_pin #(
        .ANA_RST(gi < `EPP_ANA_W)
      ) u_pin (
        .aclk(aclk),
        .aresetn(aresetn),
        .nxt_dir(nxt_dir[gi]),
        .nxt_lat(nxt_lat[gi]),
        .nxt_od(nxt_od[gi]),
        .nxt_slew(nxt_slew[gi]),
        .nxt_pu(pu_eff[gi]),
        .nxt_ana(nxt_ana_full[gi]),
        .nxt_st(nxt_thr[gi]),
        .st_in(pad_st_in[gi]),
        .ttl_in(pad_ttl_in[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe_n(pad_oe_n[gi]),
        .pad_slew_lim(pad_slew_lim[gi]),
        .pad_pullup_en(pad_pullup_en[gi]),
        .pad_analog_en(pad_analog_en[gi]),
        .pad_st_sel(pad_st_sel[gi]),
        .pin_sync(pin_sync[gi])
      );
    end
  endgenerate

  // Digital read of an analog pin is zero
  assign pin_rd = pin_sync & ~ana_full;

  // ****************************************
  // Read channel
  // ****************************************
  // Same word alignment as the data mux, so response and data agree
  assign r_mapped = ({s_axi_araddr[`EPP_ADDR_W-1:2], 2'b00} <= `EPP_OFF_CTL);

  always_comb begin
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[`EPP_ADDR_W-1:2], 2'b00})
      `EPP_OFF_PIN: rd_word[7:0] = pin_rd;
      `EPP_OFF_DIR: rd_word[7:0] = dir_ff;
      `EPP_OFF_LAT: rd_word[7:0] = lat_ff;
      `EPP_OFF_ANA: rd_word[7:0] = ana_full;
      `EPP_OFF_PU: rd_word[7:0] = pu_ff;
      `EPP_OFF_OD: rd_word[7:0] = od_ff;
      `EPP_OFF_SLEW: rd_word[7:0] = slew_ff;
      `EPP_OFF_THR: rd_word[7:0] = thr_ff;
      `EPP_OFF_CTL: rd_word[`EPP_CTL_GPD] = gpd_ff;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // One read in flight; data captured at the address edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= EPP_RESP_OKAY;
    end else if (s_axi_arvalid && ar_rdy_ff) begin
      ar_rdy_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= r_mapped ? EPP_RESP_OKAY : EPP_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      ar_rdy_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = aw_rdy_ff;
  assign s_axi_wready = w_rdy_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ar_rdy_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ****************************************
  // Checks
  // ****************************************
  a_reset_state: assert property (@(posedge aclk)
    !aresetn |=> (thr_ff == 8'h00 && ana_ff == 6'h3F
      && lat_ff == 8'h00 && pad_oe_n == 8'hFF && pad_analog_en == 8'h3F))
    else $error("reset values wrong");
  a_ana_top_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && ar_rdy_ff && s_axi_araddr == `EPP_OFF_ANA)
    |=> rdata_ff[31:6] == 26'h0)
    else $error("analog upper bits not zero");
  a_analog_rd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && ar_rdy_ff && s_axi_araddr == `EPP_OFF_PIN)
    |=> (rdata_ff[7:0] & $past(ana_full)) == 8'h00)
    else $error("analog pin read nonzero");
  a_pin_wr_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_en && waddr_ff == `EPP_OFF_PIN && rmw_mask == 8'hFF)
    |=> (lat_ff == $past(wdata_ff[7:0]) && dir_ff == $past(dir_ff)))
    else $error("pin write missed latch");
  a_rmw_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_en && waddr_ff == `EPP_OFF_PIN && rmw_mask != 8'hFF)
    |=> ((lat_ff ^ $past(pin_rd)) & ~$past(rmw_mask)) == 8'h00)
    else $error("read-modify-write lost pins");
  a_write_timing: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_en && waddr_ff == `EPP_OFF_SLEW)
    |=> (bvalid_ff && slew_ff == $past(wdata_ff[7:0])
      && pad_slew_lim == $past(wdata_ff[7:0])))
    else $error("write not applied on time");
  a_gpd_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    gpd_ff |-> pad_pullup_en == 8'h00)
    else $error("pull-up on while globally off");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && ar_rdy_ff) |=> (rvalid_ff && !ar_rdy_ff))
    else $error("read answer late");
  // One write at a time: both channels stay closed while the answer waits
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    commit |=> (bvalid_ff && !aw_rdy_ff && !w_rdy_ff))
    else $error("write answer late or channel open");
  // An unmapped write answers an error and leaves dir_ff, lat_ff and gpd_ff alone
  a_unmapped_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (commit && !w_mapped)
    |=> (bresp_ff == EPP_RESP_SLVERR && dir_ff == $past(dir_ff)
      && lat_ff == $past(lat_ff) && gpd_ff == $past(gpd_ff)))
    else $error("unmapped write stored");
endmodule

// >>> epp_pad_model.sv
/*
 Outside circuitry on the eight port pins, with both comparator outputs.
 Assumes pad controls from the port block and one clock.
*/
`timescale 1ns/1ps
module epp_pad_model (
  input wire logic aclk,
  input wire epp_pkg::epp_byte_t pad_out,
  input wire epp_pkg::epp_byte_t pad_oe_n,
  input wire epp_pkg::epp_byte_t pad_pullup_en,
  input wire epp_pkg::epp_byte_t ext_en,
  input wire epp_pkg::epp_byte_t ext_val,
  input wire epp_pkg::epp_byte_t mid_lvl,
  output epp_pkg::epp_byte_t pad_st_in,
  output epp_pkg::epp_byte_t pad_ttl_in
);
  import epp_pkg::*;
  epp_byte_t lvl;
  logic flip_ff = '0;
  // Undriven pins wander; a toggling level exposes reads of them
  always @(posedge aclk) begin
    flip_ff <= ~flip_ff;
  end
  // Pin level: block driver, then outside source, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) lvl[i] = pad_out[i];
      else if (ext_en[i]) lvl[i] = ext_val[i];
      else if (pad_pullup_en[i]) lvl[i] = 1'h1;
      else lvl[i] = flip_ff ^ i[0];
    end
  end
  // Level between thresholds: TTL sees high, Schmitt sees low
  assign pad_st_in = lvl & ~mid_lvl;
  assign pad_ttl_in = lvl | mid_lvl;
endmodule

// >>> tb_top.sv
/*
 Self-checking bench for the eight-pin port block.
 Assumes the design files and the pad model are compiled first.
*/
`timescale 1ns/1ps
`include "epp_map.svh"
module tb_top;
  import epp_pkg::*;
  // ********
  // Signals
  // ********
  logic aclk = '0;
  logic aresetn = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = '0;
  epp_word_t s_axi_wdata = '0;
  epp_word_t s_axi_rdata;
  epp_byte_t pad_st_in, pad_ttl_in, pad_out, pad_oe_n, pad_slew_lim;
  epp_byte_t pad_pullup_en, pad_analog_en, pad_st_sel;
  epp_byte_t ext_en = 8'hFF, ext_val = 8'hFF, mid_lvl = '0;
  int bad_count = 0, n_checks = 0, cyc = 0;

  // Clock, 5 ns period
  initial begin
    forever #2.5 aclk = ~aclk;
  end

  epp_port epp_port_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_st_in, .pad_ttl_in,
    .pad_out, .pad_oe_n, .pad_slew_lim, .pad_pullup_en, .pad_analog_en,
    .pad_st_sel);
  epp_pad_model epp_pad_model_inst (.aclk, .pad_out, .pad_oe_n,
    .pad_pullup_en, .ext_en, .ext_val, .mid_lvl, .pad_st_in, .pad_ttl_in);

  // ********
  // Bus tasks
  // ********
  task automatic chk(input string nm, input epp_word_t e, input epp_word_t g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask

  // One write; the extra edge first keeps bready from two drives at once
  task automatic wr(input logic [7:0] a, input epp_word_t d,
      input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'h0;
    chk("bresp", er, s_axi_bresp);
  endtask

  // One read; three idle edges let pin changes clear the synchroniser
  task automatic rd(input logic [7:0] a, input epp_word_t e,
      input logic [1:0] er);
    repeat (3) @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'h0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    epp_byte_t rv [9] = '{8'hC0, 8'hFF, 8'h00, 8'h3F, 8'hFF, 8'h00,
      8'hFF, 8'h00, 8'h01};
    chk("oe_n", 8'hFF, pad_oe_n);
    chk("out", 8'h00, pad_out);
    chk("ana", 8'h3F, pad_analog_en);
    chk("st", 8'h00, pad_st_sel);
    chk("slew", 8'hFF, pad_slew_lim);
    chk("pu", 8'h00, pad_pullup_en);
    for (int i = 0; i < 9; i++) begin
      rd(8'(4 * i), rv[i], 2'h0);
    end
    rd(8'h24, 32'h0000_0000, 2'h2);
    wr(8'h24, 32'h0000_00FF, 4'h1, 2'h2);
    wr(`EPP_OFF_ANA, 32'h0000_00FF, 4'h1, 2'h0);
    rd(`EPP_OFF_ANA, 8'h3F, 2'h0);
  endtask

  task automatic t_drive();
    ext_en <= 8'hF0;
    ext_val <= 8'h30;
    wr(`EPP_OFF_ANA, 32'h0000_0000, 4'h1, 2'h0);
    wr(`EPP_OFF_LAT, 32'h0000_00A5, 4'h1, 2'h0);
    wr(`EPP_OFF_DIR, 32'h0000_00F0, 4'h1, 2'h0);
    chk("oe_n", 8'hF0, pad_oe_n);
    chk("out", 8'hA5, pad_out);
    rd(`EPP_OFF_PIN, 8'h35, 2'h0);
    // Masked pin write: (35 & FC) | 02
    wr(`EPP_OFF_PIN, 32'h0000_0302, 4'h3, 2'h0);
    rd(`EPP_OFF_LAT, 8'h36, 2'h0);
    wr(`EPP_OFF_PIN, 32'h0000_00C9, 4'h1, 2'h0);
    rd(`EPP_OFF_PIN, 8'h39, 2'h0);
    // Analog output pin keeps driving but reads zero
    wr(`EPP_OFF_ANA, 32'h0000_0001, 4'h1, 2'h0);
    chk("oe_n", 8'hF0, pad_oe_n);
    chk("out", 8'hC9, pad_out);
    chk("ana", 8'h01, pad_analog_en);
    rd(`EPP_OFF_PIN, 8'h38, 2'h0);
    wr(`EPP_OFF_PIN, 32'h0000_0200, 4'h3, 2'h0);
    rd(`EPP_OFF_LAT, 8'h38, 2'h0);
    wr(`EPP_OFF_ANA, 32'h0000_0000, 4'h1, 2'h0);
  endtask

  task automatic t_drain_pull();
    wr(`EPP_OFF_OD, 32'h0000_000F, 4'h1, 2'h0);
    chk("oe_n", 8'hF8, pad_oe_n);
    wr(`EPP_OFF_OD, 32'h0000_0000, 4'h1, 2'h0);
    chk("oe_n", 8'hF0, pad_oe_n);
    ext_en <= 8'h00;
    wr(`EPP_OFF_CTL, 32'h0000_0000, 4'h1, 2'h0);
    chk("pu", 8'hF0, pad_pullup_en);
    rd(`EPP_OFF_PIN, 8'hF8, 2'h0);
    wr(`EPP_OFF_CTL, 32'h0000_0001, 4'h1, 2'h0);
    chk("pu", 8'h00, pad_pullup_en);
  endtask

  // Threshold changes made with nothing else active
  task automatic t_thr();
    ext_en <= 8'hFF;
    ext_val <= 8'h0F;
    mid_lvl <= 8'hF0;
    wr(`EPP_OFF_DIR, 32'h0000_00FF, 4'h1, 2'h0);
    rd(`EPP_OFF_PIN, 8'hFF, 2'h0);
    wr(`EPP_OFF_THR, 32'h0000_00FF, 4'h1, 2'h0);
    chk("st", 8'hFF, pad_st_sel);
    rd(`EPP_OFF_PIN, 8'h0F, 2'h0);
    wr(`EPP_OFF_THR, 32'h0000_003C, 4'h1, 2'h0);
    rd(`EPP_OFF_PIN, 8'hCF, 2'h0);
    rd(`EPP_OFF_THR, 8'h3C, 2'h0);
  endtask

  task automatic t_slew();
    wr(`EPP_OFF_SLEW, 32'h0000_005A, 4'h1, 2'h0);
    chk("slew", 8'h5A, pad_slew_lim);
    wr(`EPP_OFF_SLEW, 32'h0000_00FF, 4'h0, 2'h0);
    rd(`EPP_OFF_SLEW, 8'h5A, 2'h0);
  endtask

  // ********
  // Run control
  // ********
  // Reset in mid-run brings pads and registers back to their start
  task automatic t_rst2();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk("slew", 8'hFF, pad_slew_lim);
    chk("ana", 8'h3F, pad_analog_en);
    chk("oe_n", 8'hFF, pad_oe_n);
    chk("st", 8'h00, pad_st_sel);
    rd(`EPP_OFF_THR, 8'h00, 2'h0);
  endtask

  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // Reset for ten cycles, then the scenarios
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_drive();
    t_drain_pull();
    t_thr();
    t_slew();
    t_rst2();
    finish_test();
  end
endmodule
